// ===== bench/capture_source.sv
// Far-side model: an external signal source on the capture inputs.
// Assumes its tasks are called from the bench right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module capture_source
  import tcc_pkg::*;
(
  input wire logic clk,
  output logic [num_chan-1:0] level_a,
  output logic [num_chan-1:0] level_b
);
  // ==========================================
  // Quiet levels until a scenario asks for an edge
  initial begin
    level_a = '0;
    level_b = '0;
  end
  // New level lands just after an edge; hold makes the source slow or prompt
  task automatic drive_a(input int ch, input logic v, input int hold);
    @(posedge clk);
    level_a[ch] <= v;
    repeat (hold) @(posedge clk);
  endtask
  task automatic drive_b(input int ch, input logic v, input int hold);
    @(posedge clk);
    level_b[ch] <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench: AXI4-Lite register tasks and scenario sequences.
// Assumes the timer package and the capture source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tcc_pkg::*;
();
  logic clk, resetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd, cnt, expv, prev_rd;
  logic top_ok, down_seen, tgl_seen, prev_out;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, hit, exp_hit;
  logic [1:0] bresp, rresp, rsp;
  logic [num_chan-1:0] in_a, in_b, chan_out, chan_irq;
  int num_errors = 0;
  int n_checks = 0;
  int e, lv, s, r, k;
  // ==========================================
  // Design and far-side source
  timer_capture_compare_channel dut_u (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_input_a(in_a), .external_input_b(in_b), .chan_out(chan_out),
    .chan_irq(chan_irq));
  capture_source src_u (.clk(clk), .level_a(in_a), .level_b(in_b));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // Verdict, comparison and hang handling
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    num_errors++;
    $display("Error t=%0t %s timed out", $time, what);
    give_verdict();
  endtask
  // ==========================================
  // Bus tasks; each opens with an edge so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_p, w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw_p || w_p) && n < 50) begin
      @(posedge clk);
      n++;
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do begin
      @(posedge clk);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 50) hang("write");
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 50) hang("read");
  endtask
  // Reads a register until one bit shows; a miss is a result, not a hang
  task automatic poll(input logic [7:0] a, input int pos);
    hit = 1'b0;
    for (int i = 0; i < 12 && hit !== 1'b1; i++) begin
      rd_reg(a);
      hit = rd[pos];
    end
  endtask
  function automatic logic [7:0] ca(input int ch);
    return control_base + 8'(ch * 4);
  endfunction
  function automatic logic [7:0] va(input int ch);
    return value_base + 8'(ch * 4);
  endfunction
  // Control word; load policy stays 00 so value writes reach the latch at once
  function automatic logic [31:0] ctl(input logic [1:0] e2, input logic [1:0] s2,
    input logic y, input logic f, input logic [2:0] m, input logic ie, input logic d);
    return (32'(e2) << edge_pos) | (32'(s2) << src_pos) | (32'(y) << sync_pos) |
      (32'(f) << func_pos) | (32'(m) << action_pos) | (32'(ie) << irq_en_pos) |
      (32'(d) << direct_pos);
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(counter_off);
    chk(rd, 32'h0, "counter reset"); // zero at reset
    for (k = 0; k < num_chan; k++) begin
      rd_reg(ca(k));
      chk(rd & ~(32'h1 << level_pos), 32'h0, "control reset"); // fields clear
      rd_reg(va(k));
      chk(rd, 32'h0, "value reset"); // value clear
    end
    wr(counter_off, 32'hffff_a5c3);
    rd_reg(counter_off);
    chk(rd, 32'h0000_a5c3, "counter rw"); // read and write
    rd_reg(8'hfc);
    chk({rd[29:0], rsp}, {30'h0, resp_slverr}, "unmapped read");
    wr(8'hfc, 32'h1);
    chk(32'(rsp), 32'(resp_slverr), "unmapped write");
    // direct level drives the pin in mode 0
    for (k = 1; k >= 0; k--) begin
      wr(ca(0), ctl(2'h0, 2'h0, 1'b0, 1'b0, 3'h0, 1'b0, k[0]));
      rd_reg(ca(0));
      chk(32'(chan_out[0]), 32'(k), "direct out"); // pin follows bit
    end
    // source select seen through the level bit
    for (r = 0; r < 2; r++) begin
      src_u.drive_a(0, r == 0, 0);
      src_u.drive_b(0, r == 1, 1);
      for (s = 0; s < 4; s++) begin
        wr(ca(0), ctl(2'h0, 2'(s), 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
        rd_reg(ca(0));
        chk(32'(rd[level_pos]), 32'(s == 3 || s == r), "level"); // selected level
      end
    end
    src_u.drive_a(0, 1'b0, 0);
    src_u.drive_b(0, 1'b0, 0);
    // edge modes capture the stopped count on channel 1
    expv = 32'h0;
    for (e = 1; e < 4; e++) begin
      for (lv = 1; lv >= 0; lv--) begin
        cnt = 32'h40 + 32'(e) + (lv == 1 ? 32'h0 : 32'h100);
        wr(counter_off, cnt);
        wr(ca(1), ctl(2'(e), 2'h0, 1'b1, 1'b1, 3'h0, 1'b0, 1'b0));
        src_u.drive_a(1, lv[0], 3);
        poll(ca(1), event_pos);
        exp_hit = (lv == 1) ? (e != 2) : (e != 1);
        chk(32'(hit), 32'(exp_hit), "edge capture"); // trigger edge
        chk(32'(rd[overrun_pos]), 32'h0, "no overrun"); // value was read
        chk(32'(chan_irq[1]), 32'h0, "irq masked"); // disabled request
        if (exp_hit) expv = cnt;
        rd_reg(va(1));
        chk(rd, expv, "captured count"); // count copied
      end
    end
    // overrun on unread recapture, async path, cleared by software
    wr(ca(1), ctl(2'h3, 2'h0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0));
    src_u.drive_a(1, 1'b1, 0);
    poll(ca(1), event_pos);
    chk(32'(hit), 32'h1, "async capture"); // unsynchronised capture
    src_u.drive_a(1, 1'b0, 0);
    poll(ca(1), overrun_pos);
    chk(32'(hit), 32'h1, "overrun set"); // unread recapture
    rd_reg(ca(1));
    chk(32'(rd[overrun_pos]), 32'h1, "overrun kept"); // hardware never clears
    chk(rd, ctl(2'h3, 2'h0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0) | 32'h3, "control readback"); // fields
    wr(ca(1), ctl(2'h0, 2'h0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0));
    rd_reg(ca(1));
    chk(32'(rd[overrun_pos]), 32'h0, "overrun cleared"); // software clear
    // compare match in up mode drives set then reset on channel 2
    wr(ca(0), 32'h0);
    wr(va(0), 32'h20);
    for (k = 0; k < 2; k++) begin
      wr(timer_ctl_off, 32'h0);
      wr(counter_off, 32'h0);
      wr(ca(2), ctl(2'h0, 2'h0, 1'b0, 1'b0, (k == 0) ? 3'h1 : 3'h5, 1'b1, 1'b0));
      wr(va(2), 32'h10);
      wr(timer_ctl_off, 32'(mode_up) << mode_pos);
      poll(ca(2), event_pos);
      chk(32'(hit), 32'h1, "match flag"); // counter meets latch
      chk(32'(chan_out[2]), 32'(k == 0), "pin action"); // set and reset modes
      chk(32'(chan_irq[2]), 32'h1, "irq raised"); // enabled request
    end
    // up/down on period 0x20: reads never exceed it and show small down steps
    wr(timer_ctl_off, 32'h0);
    wr(counter_off, 32'h0);
    wr(ca(1), ctl(2'h0, 2'h0, 1'b0, 1'b0, 3'h4, 1'b1, 1'b0));
    wr(va(1), 32'h8);
    wr(timer_ctl_off, 32'(mode_updown) << mode_pos);
    top_ok = 1'b1;
    down_seen = 1'b0;
    tgl_seen = 1'b0;
    rd_reg(counter_off);
    for (k = 0; k < 30; k++) begin
      prev_rd = rd;
      prev_out = chan_out[1];
      rd_reg(counter_off);
      if (rd[15:0] > 16'h0020) top_ok = 1'b0;
      if (rd[15:0] < prev_rd[15:0] && prev_rd[15:0] - rd[15:0] < 16'h0008) down_seen = 1'b1;
      if (chan_out[1] !== prev_out) tgl_seen = 1'b1;
    end
    chk(32'(top_ok), 32'h1, "updown ceiling"); // never above period
    chk(32'(down_seen), 32'h1, "updown descent"); // counts back down
    chk(32'(tgl_seen), 32'h1, "toggle action"); // toggle on match
    rd_reg(ca(1));
    chk(32'(rd[event_pos]), 32'h1, "match flag ch1"); // flag on match
    chk(32'(chan_irq[1]), 32'h1, "irq ch1"); // enabled request
    wr(timer_ctl_off, 32'h0);
    rd_reg(va(2));
    chk(rd, 32'h10, "compare value"); // value kept in compare
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== rtl/tcc_pkg.sv
// Constants, field layout and bus carriers for the capture/compare timer.
// Assumes a 100 MHz single clock and an AXI4-Lite master that keeps to the protocol.
package tcc_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] counter_off = 8'h00;
  localparam logic [7:0] timer_ctl_off = 8'h04;
  localparam logic [7:0] control_base = 8'h10;
  localparam logic [7:0] value_base = 8'h30;
  localparam int num_chan = 3;
  localparam logic [15:0] counter_rst = 16'h0000;
  localparam logic [15:0] value_rst = 16'h0000;
  // ==========================================
  // Channel control field positions
  localparam int edge_pos = 14;
  localparam int src_pos = 12;
  localparam int sync_pos = 11;
  localparam int load_pos = 9;
  localparam int func_pos = 8;
  localparam int action_pos = 5;
  localparam int irq_en_pos = 4;
  localparam int level_pos = 3;
  localparam int direct_pos = 2;
  localparam int overrun_pos = 1;
  localparam int event_pos = 0;
  // Timer control: count mode in bits 5-4
  localparam int mode_pos = 4;
  localparam logic [1:0] mode_stop = 2'h0;
  localparam logic [1:0] mode_up = 2'h1;
  localparam logic [1:0] mode_cont = 2'h2;
  localparam logic [1:0] mode_updown = 2'h3;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef struct packed {
    logic [1:0] edge_select;
    logic [1:0] input_source_select;
    logic input_sync_enable;
    logic [1:0] latch_load_policy;
    logic channel_function_select;
    logic [2:0] pin_action_mode;
    logic channel_irq_enable;
    logic direct_level_bit;
    logic overrun_flag;
    logic channel_event_flag;
  } chan_ctl_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } bus_word_t;
endpackage

// ===== rtl/timer_capture_compare_channel.sv
// Counter and capture/compare channels behind an AXI4-Lite slave.
// Assumes pins are synchronous to clk unless the input synchroniser is enabled.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_channel
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [num_chan-1:0] external_input_a,
  input wire logic [num_chan-1:0] external_input_b,
  output logic [num_chan-1:0] chan_out,
  output logic [num_chan-1:0] chan_irq
);
  // Channel index decode, used by both read and write paths
  function automatic int chan_of(input logic [7:0] a, input logic [7:0] base);
    chan_of = ((a >= base) && (a < base + 8'(4*num_chan)) && (a[1:0] == 2'h0)) ?
              int'((a - base) >> 2) : -1;
  endfunction

  // ==========================================
  // Bus slave state
  bus_word_t aw_ff, nxt_aw;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic do_write;
  // ==========================================
  // Timer state
  logic [15:0] counter_ff, nxt_counter;
  logic [1:0] count_mode_ff, nxt_count_mode;
  logic down_ff, nxt_down;
  chan_ctl_t ctl_ff [num_chan], nxt_ctl [num_chan];
  logic [15:0] value_ff [num_chan], nxt_value [num_chan];
  logic [15:0] latch_ff [num_chan], nxt_latch [num_chan];
  logic [num_chan-1:0] in_s1_ff, in_s2_ff, prev_ff, nxt_prev, unread_ff, nxt_unread;
  logic [num_chan-1:0] out_ff, nxt_out, irq_ff, nxt_irq, level_ff, nxt_level;
  logic [num_chan-1:0] sel_in, cap_in, cap_evt, match_pulse;
  logic counting, at_zero, at_period, period_match_pulse;

  // Write happens once both address and data are held and no answer is pending
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

  // Write channel handshake, either order accepted
  always_comb begin
    nxt_aw = aw_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_wstrb = wstrb_ff;
    nxt_awready = !aw_have_ff && !(s_axi_awvalid && awready_ff);
    nxt_wready = !w_have_ff && !(s_axi_wvalid && wready_ff);
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw.addr = s_axi_awaddr;
      nxt_aw_have = 1'b1;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_aw.data = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
      nxt_w_have = 1'b1;
    end
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (aw_ff.addr == counter_off || aw_ff.addr == timer_ctl_off ||
                   chan_of(aw_ff.addr, control_base) >= 0 ||
                   chan_of(aw_ff.addr, value_base) >= 0) ? resp_okay : resp_slverr;
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  always_comb begin
    int c;
    c = -1;
    nxt_arready = !rvalid_ff && !(s_axi_arvalid && arready_ff);
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = resp_okay;
      nxt_rdata = 32'h0000_0000;
      if (s_axi_araddr == counter_off) begin
        nxt_rdata[15:0] = counter_ff;
      end else if (s_axi_araddr == timer_ctl_off) begin
        nxt_rdata[mode_pos+:2] = count_mode_ff;
      end else if (chan_of(s_axi_araddr, control_base) >= 0) begin
        c = chan_of(s_axi_araddr, control_base);
        nxt_rdata[15:0] = {ctl_ff[c][14:3], level_ff[c], ctl_ff[c][2:0]};
      end else if (chan_of(s_axi_araddr, value_base) >= 0) begin
        c = chan_of(s_axi_araddr, value_base);
        nxt_rdata[15:0] = value_ff[c];
      end else begin
        nxt_rresp = resp_slverr;
      end
    end
  end

  // Counter: stop, up to period, continuous, up/down
  assign counting = (count_mode_ff != mode_stop);
  assign at_zero = counting && (counter_ff == 16'h0000);
  assign at_period = counting && (counter_ff == latch_ff[0]);
  assign period_match_pulse = at_period;
  always_comb begin
    nxt_counter = counter_ff;
    nxt_down = down_ff;
    nxt_count_mode = count_mode_ff;
    case (count_mode_ff)
      mode_up: nxt_counter = (counter_ff >= latch_ff[0]) ? 16'h0000 : counter_ff + 16'h0001;
      mode_cont: nxt_counter = counter_ff + 16'h0001;
      mode_updown: begin
        if (!down_ff && counter_ff >= latch_ff[0]) begin
          nxt_down = 1'b1;
          nxt_counter = counter_ff - 16'h0001;
        end else if (down_ff && counter_ff == 16'h0000) begin
          nxt_down = 1'b0;
          nxt_counter = counter_ff + 16'h0001;
        end else begin
          nxt_counter = down_ff ? counter_ff - 16'h0001 : counter_ff + 16'h0001;
        end
      end
      default: nxt_counter = counter_ff;
    endcase
    if (do_write && aw_ff.addr == counter_off) begin
      nxt_counter = aw_ff.data[15:0];
    end
    if (do_write && aw_ff.addr == timer_ctl_off) begin
      nxt_count_mode = aw_ff.data[mode_pos+:2];
      nxt_down = 1'b0;
    end
  end

  // Per-channel input selection and edge detection
  genvar g;
  for (g = 0; g < num_chan; g++) begin : g_in
    // source mux; upper code bit picks a constant, its low bit is the level
    assign sel_in[g] = ctl_ff[g].input_source_select[1] ? ctl_ff[g].input_source_select[0] :
      (ctl_ff[g].input_source_select[0] ? external_input_b[g] : external_input_a[g]);
    // sync or direct path; direct path still samples once for edge detection
    assign cap_in[g] = ctl_ff[g].input_sync_enable ? in_s2_ff[g] : sel_in[g];
    assign cap_evt[g] = ctl_ff[g].channel_function_select &&
      ((ctl_ff[g].edge_select[0] && cap_in[g] && !prev_ff[g]) ||
       (ctl_ff[g].edge_select[1] && !cap_in[g] && prev_ff[g]));
    assign match_pulse[g] = counting && !ctl_ff[g].channel_function_select &&
                            (counter_ff == latch_ff[g]);
  end

  // Channel register and output update
  always_comb begin
    for (int i = 0; i < num_chan; i++) begin
      nxt_ctl[i] = ctl_ff[i];
      nxt_value[i] = value_ff[i];
      nxt_latch[i] = latch_ff[i];
      nxt_unread[i] = unread_ff[i];
      nxt_prev[i] = cap_in[i];
      nxt_level[i] = cap_in[i];
      nxt_out[i] = out_ff[i];
      if (do_write && chan_of(aw_ff.addr, control_base) == i && wstrb_ff[1:0] != 2'h0) begin
        nxt_ctl[i] = chan_ctl_t'({aw_ff.data[15:4], aw_ff.data[2:0]});
      end
      if (s_axi_arvalid && arready_ff && chan_of(s_axi_araddr, value_base) == i) begin
        nxt_unread[i] = 1'b0;
      end
      if (do_write && chan_of(aw_ff.addr, value_base) == i) begin
        nxt_value[i] = aw_ff.data[15:0];
        if (ctl_ff[i].latch_load_policy == 2'h0) nxt_latch[i] = aw_ff.data[15:0];
      end
      // Load policies tied to counter events
      case (ctl_ff[i].latch_load_policy)
        2'h1: if (at_zero) nxt_latch[i] = value_ff[i];
        2'h2: if (at_zero || (count_mode_ff == mode_updown && at_period))
          nxt_latch[i] = value_ff[i];
        2'h3: if (counting && counter_ff == latch_ff[i]) nxt_latch[i] = value_ff[i];
        default: nxt_latch[i] = nxt_latch[i];
      endcase
      if (cap_evt[i]) begin
        nxt_value[i] = counter_ff;
        if (unread_ff[i]) nxt_ctl[i].overrun_flag = 1'b1;
        nxt_unread[i] = 1'b1;
      end
      if (cap_evt[i] || match_pulse[i]) nxt_ctl[i].channel_event_flag = 1'b1;
      // output action; compare path feeds match
      // channel 0 modes 2,3,6,7: its match is the period match, so the match action wins
      case (ctl_ff[i].pin_action_mode)
        3'h0: nxt_out[i] = ctl_ff[i].direct_level_bit;
        3'h1: if (match_pulse[i]) nxt_out[i] = 1'b1;
        3'h2: if (match_pulse[i]) nxt_out[i] = !out_ff[i];
              else if (period_match_pulse) nxt_out[i] = 1'b0;
        3'h3: if (match_pulse[i]) nxt_out[i] = 1'b1;
              else if (period_match_pulse) nxt_out[i] = 1'b0;
        3'h4: if (match_pulse[i]) nxt_out[i] = !out_ff[i];
        3'h5: if (match_pulse[i]) nxt_out[i] = 1'b0;
        3'h6: if (match_pulse[i]) nxt_out[i] = !out_ff[i];
              else if (period_match_pulse) nxt_out[i] = 1'b1;
        default: if (match_pulse[i]) nxt_out[i] = 1'b0;
                 else if (period_match_pulse) nxt_out[i] = 1'b1;
      endcase
      nxt_irq[i] = nxt_ctl[i].channel_event_flag && nxt_ctl[i].channel_irq_enable;
    end
  end

  // Register all state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_ff <= '0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= resp_okay;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= resp_okay;
      counter_ff <= counter_rst;
      count_mode_ff <= mode_stop;
      down_ff <= 1'b0;
      in_s1_ff <= '0;
      in_s2_ff <= '0;
      prev_ff <= '0;
      unread_ff <= '0;
      out_ff <= '0;
      irq_ff <= '0;
      level_ff <= '0;
      for (int i = 0; i < num_chan; i++) begin
        ctl_ff[i] <= '0;
        value_ff[i] <= value_rst;
        latch_ff[i] <= value_rst;
      end
    end else begin
      aw_ff <= nxt_aw;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      counter_ff <= nxt_counter;
      count_mode_ff <= nxt_count_mode;
      down_ff <= nxt_down;
      in_s1_ff <= sel_in;
      in_s2_ff <= in_s1_ff;
      prev_ff <= nxt_prev;
      unread_ff <= nxt_unread;
      out_ff <= nxt_out;
      irq_ff <= nxt_irq;
      level_ff <= nxt_level;
      for (int i = 0; i < num_chan; i++) begin
        ctl_ff[i] <= nxt_ctl[i];
        value_ff[i] <= nxt_value[i];
        latch_ff[i] <= nxt_latch[i];
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign chan_out = out_ff;
  assign chan_irq = irq_ff;

  // ==========================================
  // Checks
  // write lands
  a_counter_write: assert property (@(posedge clk) disable iff (!resetn)
    do_write && aw_ff.addr == counter_off |=> counter_ff == $past(aw_ff.data[15:0]))
    else $error("counter write lost");
  a_capture_copy: assert property (@(posedge clk) disable iff (!resetn)
    cap_evt[1] |=> value_ff[1] == $past(counter_ff))
    else $error("capture value wrong");
  a_event_flag: assert property (@(posedge clk) disable iff (!resetn)
    match_pulse[1] |=> ctl_ff[1].channel_event_flag)
    else $error("event flag not set");
  a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
    chan_irq[1] |-> ctl_ff[1].channel_irq_enable && ctl_ff[1].channel_event_flag)
    else $error("irq without enable");
  a_direct_level: assert property (@(posedge clk) disable iff (!resetn)
    ctl_ff[1].pin_action_mode == 3'h0 |=> chan_out[1] == $past(ctl_ff[1].direct_level_bit))
    else $error("direct output wrong");
  a_overrun_set: assert property (@(posedge clk) disable iff (!resetn)
    cap_evt[1] && unread_ff[1] |=> ctl_ff[1].overrun_flag)
    else $error("overrun not flagged");
  a_updown_turn: assert property (@(posedge clk) disable iff (!resetn)
    count_mode_ff == mode_updown && !down_ff && counter_ff == latch_ff[0] &&
    latch_ff[0] != 16'h0000 && !do_write |=> down_ff)
    else $error("no reversal");
  a_latch_now: assert property (@(posedge clk) disable iff (!resetn)
    do_write && chan_of(aw_ff.addr, value_base) == 1 && ctl_ff[1].latch_load_policy == 2'h0
    |=> latch_ff[1] == $past(aw_ff.data[15:0]))
    else $error("latch not loaded");
endmodule
`default_nettype wire
